//--- verilog/psf_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Contract
// - read-only length estimate in bits 15:13, resets 000
// - estimate invalid while fixed gain bit set
// - read/write rise-time select in bits 11:10
// - rise-time field loaded from straps at reset
// - bit 9 crossover enable, resets one
// - bit 8 pair select, MDIX when one
// - bit 7 analog loopback enable, resets zero
// - bit 6 loopback detect enable, resets zero
// - bit 5 faster detection enable, resets zero
// - bit 4 read-only loopback detected status
module psf_top
  import psf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and analog status
  input wire logic [1:0] rise_time_strap_pins,
  input wire logic [2:0] line_length_in,
  input wire logic fixed_gain_set,
  input wire logic loop_cond_in,
  // control outputs
  output logic [1:0] rise_time_sel,
  output logic automatic_crossover,
  output logic pair_mdix,
  output logic analog_loopback,
  output logic length_valid
);
  // synchronised inputs
  logic [1:0] strap_sync;
  logic [2:0] len_sync;
  logic gain_sync;
  logic cond_sync;
  // register fields
  logic [2:0] len_reg; // captured estimate
  logic [1:0] rise_reg;
  logic xover_reg;
  logic pair_reg;
  logic aloop_reg;
  logic ldet_en_reg;
  logic ldet_fast_reg;
  logic [31:0] prdata_reg;
  psf_state_type state_reg;
  psf_state_type state_next;
  // bus decode
  logic acc;
  logic hit;
  logic wr_en;
  logic [15:0] rd_word;
  logic len_ok;

  psf_ctl_if ctl ();

  // pins from outside the clock domain, two flops each
  psf_sync2 #(.WIDTH(7)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({rise_time_strap_pins, line_length_in, fixed_gain_set,
               loop_cond_in}),
    .sync_out({strap_sync, len_sync, gain_sync, cond_sync})
  );

  // detector for loopback condition
  psf_loop_det u_det (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .cond_sync(cond_sync),
    .ctl(ctl)
  );

  // strap load sequencing: wait for synchroniser to fill
  always_comb begin
    case (state_reg)
      PSF_ST_RESET: state_next = PSF_ST_SYNC;
      PSF_ST_SYNC: state_next = PSF_ST_LOAD;
      PSF_ST_LOAD: state_next = PSF_ST_RUN;
      PSF_ST_RUN: state_next = PSF_ST_RUN;
      default: state_next = PSF_ST_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_reg <= PSF_ST_RESET;
    else if (clk_en) state_reg <= state_next;
  end

  // apb: zero wait states, any unmapped address errors
  assign acc = psel && penable;
  assign hit = (paddr == SFC_ADDR);
  assign wr_en = acc && pwrite && hit && clk_en;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // estimate is meaningless with fixed gain
  assign len_ok = !gain_sync;

  // estimate latch; field reads zero while invalid
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) len_reg <= LEN_RST;
    else if (clk_en) len_reg <= len_ok ? len_sync : LEN_RST;
  end

  // rise-time field: strap load once, then software
  // the reset value is a constant; the strap lands three enabled cycles later
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rise_reg <= RISE_3P3;
    else if (clk_en && state_reg == PSF_ST_LOAD)
      rise_reg <= strap_sync;
    else if (wr_en && state_reg == PSF_ST_RUN)
      rise_reg <= pwdata[RISE_HI:RISE_LO];
  end

  // read/write control bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xover_reg <= XOVER_RST;
      pair_reg <= PAIR_RST;
      aloop_reg <= ALOOP_RST;
      ldet_en_reg <= LDET_EN_RST;
      ldet_fast_reg <= LDET_FAST_RST;
    end else if (wr_en) begin
      xover_reg <= pwdata[XOVER_BIT];
      pair_reg <= pwdata[PAIR_BIT];
      aloop_reg <= pwdata[ALOOP_BIT];
      ldet_en_reg <= pwdata[LDET_EN_BIT];
      ldet_fast_reg <= pwdata[LDET_FAST_BIT];
    end
  end

  assign ctl.det_enable = ldet_en_reg;
  assign ctl.det_fast = ldet_fast_reg;

  // read word; reserved bits always read zero
  always_comb begin
    rd_word = 16'h0000;
    rd_word[LEN_HI:LEN_LO] = len_reg;
    rd_word[RISE_HI:RISE_LO] = rise_reg;
    rd_word[XOVER_BIT] = xover_reg;
    rd_word[PAIR_BIT] = pair_reg;
    rd_word[ALOOP_BIT] = aloop_reg;
    rd_word[LDET_EN_BIT] = ldet_en_reg;
    rd_word[LDET_FAST_BIT] = ldet_fast_reg;
    rd_word[LDET_STAT_BIT] = ctl.det_found;
  end

  // read data flop, loaded during the setup phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) prdata_reg <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite)
      prdata_reg <= hit ? {16'h0000, rd_word} : 32'h0000_0000;
  end
  assign prdata = prdata_reg;

  // control outputs from flops; length_valid is the inverted gain flop
  assign rise_time_sel = rise_reg;
  assign automatic_crossover = xover_reg;
  assign pair_mdix = pair_reg;
  assign analog_loopback = aloop_reg;
  assign length_valid = len_ok;

  // assertions
  a_len_invalid_zero: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && gain_sync |=> len_reg == LEN_RST)
    else $error("length not cleared under fixed gain");
  a_len_follows_in: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && !gain_sync |=> len_reg == $past(len_sync))
    else $error("length estimate not captured");
  a_rise_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_en && state_reg == PSF_ST_RUN |=>
    rise_reg == $past(pwdata[RISE_HI:RISE_LO]))
    else $error("rise field write lost");
  a_rise_strap: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && state_reg == PSF_ST_LOAD |=> rise_reg == $past(strap_sync))
    else $error("strap not loaded");
  a_xover_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_en |=> automatic_crossover == $past(pwdata[XOVER_BIT]))
    else $error("crossover bit write lost");
  a_pair_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !wr_en |=> $stable(pair_mdix))
    else $error("pair select changed without write");
  a_aloop_write: assert property (@(posedge clock) disable iff (!rst_b)
    wr_en |=> analog_loopback == $past(pwdata[ALOOP_BIT]))
    else $error("loopback bit write lost");
  a_det_off_clear: assert property (@(posedge clock) disable iff (!rst_b)
    clk_en && !ldet_en_reg |=> !ctl.det_found)
    else $error("detect status set while disabled");
  a_det_fast_qual: assert property (@(posedge clock) disable iff (!rst_b)
    ldet_en_reg && ldet_fast_reg && cond_sync && clk_en ##1
    (ldet_en_reg && ldet_fast_reg && cond_sync && clk_en)[*8]
    |=> ctl.det_found)
    else $error("fast detection did not qualify");
  a_rsv_zero: assert property (@(posedge clock) disable iff (!rst_b)
    rd_word[RSV_BIT] == 1'b0 && rd_word[3:0] == 4'h0)
    else $error("reserved bits read nonzero");

  // field-by-field write and hold checks
  // holds matter as much as writes: a stray update of a control bit
  // would silently change the line behaviour of the port

  // pair select takes the written bit
  a_pair_write: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en |=> pair_mdix == $past(pwdata[PAIR_BIT]))
    else $error("pair select write lost");

  // crossover enable only moves on a write
  a_xover_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    !wr_en |=> $stable(xover_reg))
    else $error("crossover changed without write");

  // analog loopback only moves on a write
  a_aloop_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    !wr_en |=> $stable(aloop_reg))
    else $error("loopback changed without write");

  // detection enable takes the written bit
  a_en_write: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en |=> ldet_en_reg == $past(pwdata[LDET_EN_BIT]))
    else $error("detect enable write lost");

  // detection enable only moves on a write
  a_en_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    !wr_en |=> $stable(ldet_en_reg))
    else $error("detect enable changed without write");

  // speed-up takes the written bit
  a_fast_write: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en |=> ldet_fast_reg == $past(pwdata[LDET_FAST_BIT]))
    else $error("speed-up write lost");

  // speed-up only moves on a write
  a_fast_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    !wr_en |=> $stable(ldet_fast_reg))
    else $error("speed-up changed without write");

  // rise field moves only on strap load or a run-time write
  a_rise_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    !(wr_en && state_reg == PSF_ST_RUN) &&
    !(clk_en && state_reg == PSF_ST_LOAD) |=> $stable(rise_reg))
    else $error("rise field changed unexpectedly");

  // early writes never beat the strap load
  a_rise_early_drop: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en && state_reg != PSF_ST_RUN && state_reg != PSF_ST_LOAD
    |=> $stable(rise_reg))
    else $error("rise written before strap load");

  // strap sequencing steps once per enabled cycle
  a_seq_reset: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && state_reg == PSF_ST_RESET |=> state_reg == PSF_ST_SYNC)
    else $error("strap sequence stuck in reset");

  a_seq_sync: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && state_reg == PSF_ST_SYNC |=> state_reg == PSF_ST_LOAD)
    else $error("strap sequence stuck in sync");

  // load happens exactly once per hardware reset
  a_load_to_run: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && state_reg == PSF_ST_LOAD |=> state_reg == PSF_ST_RUN)
    else $error("strap load repeated");

  a_run_stays: assert property (
    @(posedge clock) disable iff (!rst_b)
    state_reg == PSF_ST_RUN |=> state_reg == PSF_ST_RUN)
    else $error("left run state without reset");

  // read data is the register word captured at setup
  a_rd_capture: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && psel && !penable && !pwrite && hit
    |=> prdata[15:0] == $past(rd_word))
    else $error("read word not captured");

  // upper half of the bus word is never used
  a_rd_upper_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    prdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");

  // unmapped reads return zero
  a_rd_unmapped_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && psel && !penable && !pwrite && !hit
    |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // clock enable low freezes the rise and crossover fields and the length estimate
  a_freeze_fields: assert property (
    @(posedge clock) disable iff (!rst_b)
    !clk_en |=> $stable(rise_reg) && $stable(xover_reg) &&
    $stable(len_reg))
    else $error("fields moved while frozen");

  // clock enable low freezes the detector result
  a_freeze_status: assert property (
    @(posedge clock) disable iff (!rst_b)
    !clk_en |=> $stable(ctl.det_found))
    else $error("status moved while frozen");

  // status only rises with condition present and detection on
  a_det_rise_cause: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(ctl.det_found) |-> $past(cond_sync) && $past(ldet_en_reg))
    else $error("status rose without cause");

  // status drops one cycle after the condition goes away
  a_det_drop_cond: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && !cond_sync |=> !ctl.det_found)
    else $error("status held without condition");

  // valid flag is the inverse of the synchronised gain setting
  a_len_valid_out: assert property (
    @(posedge clock) disable iff (!rst_b)
    length_valid == !gain_sync)
    else $error("length valid flag wrong");

  // the read word shows zero length under fixed gain
  a_len_reads_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    clk_en && gain_sync |=> rd_word[LEN_HI:LEN_LO] == LEN_RST)
    else $error("length field readable under fixed gain");
endmodule : psf_top

//--- verilog/psf_pkg.sv
package psf_pkg;
  // register index as printed (27 decimal, not a multiple of four)
  localparam logic [7:0] SFC_INDEX = 8'h1b;
  localparam logic [11:0] SFC_ADDR = 12'h06c;
  // field positions
  localparam int LEN_HI = 15;
  localparam int LEN_LO = 13;
  localparam int RSV_BIT = 12;
  localparam int RISE_HI = 11;
  localparam int RISE_LO = 10;
  localparam int XOVER_BIT = 9;
  localparam int PAIR_BIT = 8;
  localparam int ALOOP_BIT = 7;
  localparam int LDET_EN_BIT = 6;
  localparam int LDET_FAST_BIT = 5;
  localparam int LDET_STAT_BIT = 4;
  // reset values
  localparam logic [2:0] LEN_RST = 3'h0;
  localparam logic XOVER_RST = 1'b1;
  localparam logic PAIR_RST = 1'b1;
  localparam logic ALOOP_RST = 1'b0;
  localparam logic LDET_EN_RST = 1'b0;
  localparam logic LDET_FAST_RST = 1'b0;
  localparam logic LDET_STAT_RST = 1'b0;
  // rise-time codes
  localparam logic [1:0] RISE_3P3 = 2'h0;
  localparam logic [1:0] RISE_3P6 = 2'h1;
  localparam logic [1:0] RISE_3P9 = 2'h2;
  localparam logic [1:0] RISE_4P2 = 2'h3;
  // loopback detect qualification, in clock cycles
  localparam logic [7:0] LDET_SLOW_CNT = 8'h40;
  localparam logic [7:0] LDET_FAST_CNT = 8'h08;
  // reset load sequencing
  typedef enum logic [1:0] {
    PSF_ST_RESET, PSF_ST_SYNC, PSF_ST_LOAD, PSF_ST_RUN
  } psf_state_type;
endpackage : psf_pkg

//--- verilog/psf_ctl_if.sv
`timescale 1ns/1ps
// control fields passed from the register bank to the detector, and the detector result passed back
interface psf_ctl_if;
  logic det_enable; // detection on
  logic det_fast; // faster qualification
  logic det_found; // loopback seen
  modport bank (output det_enable, output det_fast, input det_found);
  modport det (input det_enable, input det_fast, output det_found);
endinterface : psf_ctl_if

//--- verilog/psf_loop_det.sv
`timescale 1ns/1ps
module psf_loop_det
  import psf_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // synchronised raw condition
  input wire logic cond_sync,
  // control
  psf_ctl_if.det ctl
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic found_reg;
  logic [7:0] limit;
  // speed-up shortens the qualification window
  assign limit = ctl.det_fast ? LDET_FAST_CNT : LDET_SLOW_CNT;
  // count only while enabled; disabled holds the result at zero
  // saturate at the limit: a rate change mid-count must not wrap around
  assign cnt_next = (!ctl.det_enable || !cond_sync) ? 8'h00 :
                    (cnt_reg >= limit) ? limit : cnt_reg + 8'h01;
  // counter and result flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
      found_reg <= LDET_STAT_RST;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      found_reg <= ctl.det_enable && (cnt_next == limit);
    end
  end
  assign ctl.det_found = found_reg;
endmodule : psf_loop_det

//--- verilog/psf_sync2.sv
`timescale 1ns/1ps
module psf_sync2 #(
  parameter int WIDTH = 1
) (
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by second
  // two-flop synchroniser
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : psf_sync2

//--- dv/psf_host_model.sv
`timescale 1ns/1ps
// apb management host, one transfer at a time
module psf_host_model (
  // clock
  input wire logic clock,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // setup, then access held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d & 16'heff0};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : psf_host_model

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  import psf_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] straps = 2'h2;
  logic [2:0] len_in = 3'h5;
  logic gain = 1'b0;
  logic clk_en = 1'b1;
  logic loop_in = 1'b0;
  logic [1:0] rise_sel;
  logic xover, mdix, aloop, len_ok;
  logic [15:0] rd;
  logic err;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  // 25 mhz clock
  always #20 clock = ~clock;
  psf_top uut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rise_time_strap_pins(straps),
    .line_length_in(len_in), .fixed_gain_set(gain),
    .loop_cond_in(loop_in), .rise_time_sel(rise_sel),
    .automatic_crossover(xover), .pair_mdix(mdix),
    .analog_loopback(aloop), .length_valid(len_ok));
  psf_host_model host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // register compare, reserved bits disregarded
  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if ((got & 16'heff0) !== (exp & 16'heff0)) begin
      fails++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : check_reg
  // pin compare: rise (two bits), crossover, mdix, loopback, valid
  task automatic check_out(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t pins got %b exp %b", $time, got, exp);
    end
  endtask : check_out
  // hold reset ten cycles, then let the strap load settle
  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : do_reset
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 1'b0, 2'h2, 5'b11000, 1'b0, 4'h0});
    check_out({rise_sel, xover, mdix, aloop, len_ok}, 6'b101101);
    gain <= 1'b1;
    repeat (4) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h0, 1'b0, 2'h2, 5'b11000, 5'h0});
    check_out({rise_sel, xover, mdix, aloop, len_ok}, 6'b101100);
    gain <= 1'b0;
    // every rise code; read-only bits written high must not stick
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, SFC_ADDR, {3'h7, 1'b0, i[1:0], 5'b01010, 5'h10},
        rd, err);
      host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
      check_reg(rd, {3'h5, 1'b0, i[1:0], 5'b01010, 5'h0});
      check_out({rise_sel, xover, mdix, aloop, len_ok},
        {i[1:0], 4'b0101});
    end
    host.xfer(1'b1, SFC_ADDR, {6'h0, 5'b10101, 5'h0}, rd, err);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10101, 5'h0});
    check_out({rise_sel, xover, mdix, aloop, len_ok}, 6'b001011);
    // condition present but detection off
    loop_in <= 1'b1;
    repeat (20) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10101, 5'h0});
    host.xfer(1'b1, SFC_ADDR, {6'h0, 5'b10011, 5'h0}, rd, err);
    repeat (16) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10011, 5'h10});
    loop_in <= 1'b0;
    repeat (4) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10011, 5'h0});
    // normal rate must not qualify as fast as speed-up does
    host.xfer(1'b1, SFC_ADDR, {6'h0, 5'b10010, 5'h0}, rd, err);
    loop_in <= 1'b1;
    repeat (20) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10010, 5'h0});
    repeat (60) @(posedge clock);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10010, 5'h10});
    // unmapped word: refused, register untouched
    host.xfer(1'b1, 12'h070, 16'h0c00, rd, err);
    check_out({5'h0, err}, 6'h01);
    host.xfer(1'b0, 12'h070, 16'h0, rd, err);
    check_reg(rd, 16'h0000);
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10010, 5'h10});
    // frozen clock enable: write dropped, status held
    clk_en <= 1'b0;
    host.xfer(1'b1, SFC_ADDR, 16'h0000, rd, err);
    clk_en <= 1'b1;
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 3'h0, 5'b10010, 5'h10});
    // new strap value taken on the next hardware reset
    straps <= 2'h1;
    do_reset();
    host.xfer(1'b0, SFC_ADDR, 16'h0, rd, err);
    check_reg(rd, {3'h5, 1'b0, 2'h1, 5'b11000, 5'h0});
    check_out({rise_sel, xover, mdix, aloop, len_ok}, 6'b011101);
    give_verdict();
  end
endmodule : tb
